// ---- design/pwm_dbuf_pkg.sv ----
// package for the polarity-aware pwm output stage with double buffering
// assumes one core clock, avalon-mm register access, 32-bit data
package pwm_dbuf_pkg;
  localparam int unsigned NUM_CH   = 4;   // compare channels
  localparam int unsigned CNT_W    = 16;  // counter and compare width
  localparam int unsigned ADDR_W   = 4;   // word address width
  // register word offsets (byte address = offset * 4)
  localparam logic [3:0] OFS_CTRL_B    = 4'h0; // lock_update and dir
  localparam logic [3:0] OFS_CTRL_CLR  = 4'h1; // control_b_clear
  localparam logic [3:0] OFS_CTRL_SET  = 4'h2; // control_b_set
  localparam logic [3:0] OFS_STATUS    = 4'h3; // buffer valid flags
  localparam logic [3:0] OFS_EVCTRL    = 4'h4; // event_control
  localparam logic [3:0] OFS_WAVE_BUF  = 4'h5; // waveform buffer
  localparam logic [3:0] OFS_PER_BUF   = 4'h6; // period buffer
  localparam logic [3:0] OFS_PATTERN_REG_BUF  = 4'h7; // pattern_reg buffer
  localparam logic [3:0] OFS_CC0_BUF   = 4'h8; // compare_channel_0..3 buffers
  localparam logic [3:0] OFS_INT_FLAG  = 4'hC; // sticky interrupt status
  localparam logic [3:0] OFS_INT_MASK  = 4'hD; // interrupt mask
  localparam logic [3:0] OFS_ACTIVE    = 4'hE; // active wave and period
  // control_b fields
  localparam int unsigned LOCK_UPDATE_BIT     = 1;
  localparam int unsigned DIR_BIT      = 0;
  localparam int unsigned CMD_LSB      = 5;
  localparam logic [2:0]  CMD_UPDATE   = 3'h3;
  // event_control fields
  localparam int unsigned MCEO_LSB     = 24;
  localparam int unsigned MCEI_LSB     = 16;
  localparam int unsigned TCEI_LSB     = 14;
  localparam int unsigned TCINV_LSB    = 12;
  // waveform register fields
  localparam int unsigned WGEN_LSB     = 0;   // 2-bit generation mode
  localparam int unsigned POL_LSB      = 16;  // wave_polarity_x
  // status bit positions
  localparam int unsigned PATTBV_BIT   = 0;
  localparam int unsigned WAVEBV_BIT   = 1;
  localparam int unsigned PERBV_BIT    = 2;
  localparam int unsigned CCBV_LSB     = 3;
  // reset values
  localparam logic [31:0] RST_ZERO     = 32'h0000_0000;
  localparam logic [CNT_W-1:0] RST_PER = 16'hFFFF;
  typedef enum logic [1:0] {
    WG_NORMAL, WG_MFRQ, WG_NPWM, WG_DSPWM
  } wave_gen_t;
endpackage : pwm_dbuf_pkg

// ---- design/pwm_dbuf.sv ----
// waveform output stage with polarity, double buffering and event gating
// assumes the counter state comes from a counter core on the same clock,
// and event inputs come from routing logic on the same clock
// Function
// - up single-slope pol0: set TOP, clear match
// - up single-slope pol1: set match, clear TOP
// - down single-slope pol0: set match, clear ZERO
// - down single-slope pol1: set ZERO, clear match
// - dual-slope pol0: set up-match, clear down-match
// - dual-slope pol1: set down-match, clear up-match
// - normal/match-frequency: polarity gives initial level
// - pattern, wave, period, compare all buffered
// - buffer-valid flag per buffer register
// - unlocked valid buffer copied at update
// - valid flags cleared by hardware after copy
// - update command applies buffers despite lock
// - channel event out enable per channel
// - channel event in enable per channel
// - counter event in enables gate inputs
// - counter event invert bits flip inputs
module pwm_dbuf
  import pwm_dbuf_pkg::*;
(
  // clock, reset, enable
  input  wire logic                          i_core_clk,
  input  wire logic                          i_rst_b,
  input  wire logic                          i_clk_en,
  // avalon-mm slave
  input  wire logic [pwm_dbuf_pkg::ADDR_W-1:0] i_address,
  input  wire logic                          i_read,
  input  wire logic                          i_write,
  input  wire logic [31:0]                   i_writedata,
  input  wire logic [3:0]                    i_byteenable,
  output logic      [31:0]                   o_readdata,
  output logic                               o_waitrequest,
  // counter state from counter core
  input  wire logic [pwm_dbuf_pkg::CNT_W-1:0] i_count,
  input  wire logic                          i_count_down,
  // events
  input  wire logic [pwm_dbuf_pkg::NUM_CH-1:0] i_ch_event,
  input  wire logic [1:0]                    i_tc_event,
  output logic      [pwm_dbuf_pkg::NUM_CH-1:0] o_ch_event,
  output logic      [pwm_dbuf_pkg::NUM_CH-1:0] o_ch_event_in,
  output logic      [1:0]                    o_tc_event,
  // waveform and interrupt
  output logic      [pwm_dbuf_pkg::NUM_CH-1:0] o_wave,
  output logic      [pwm_dbuf_pkg::NUM_CH-1:0] o_pattern,
  output logic      [pwm_dbuf_pkg::CNT_W-1:0] o_period,
  output logic                               o_irq
);
  import pwm_dbuf_pkg::*;

  // merge write data into an old value under byte enables
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
      begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction : be_merge

  // registers
  logic [31:0]      ctrl_r, ctrl_nxt;        // lock_update, dir
  logic [31:0]      evctrl_r, evctrl_nxt;    // event_control
  logic [31:0]      wave_r, wave_nxt;        // active waveform
  logic [31:0]      wave_buf_r, wave_buf_nxt;
  logic [CNT_W-1:0] per_r, per_nxt;          // active period
  logic [CNT_W-1:0] per_buf_r, per_buf_nxt;
  logic [7:0]       pattern_reg_r, pattern_reg_nxt;        // active pattern
  logic [7:0]       pattern_reg_buf_r, pattern_reg_buf_nxt;
  logic [CNT_W-1:0] cc_r     [NUM_CH];       // active compare
  logic [CNT_W-1:0] cc_nxt   [NUM_CH];
  logic [CNT_W-1:0] cc_buf_r [NUM_CH];       // compare buffers
  logic [CNT_W-1:0] cc_buf_nxt [NUM_CH];
  logic [6:0]       bufv_r, bufv_nxt;        // buffer valid flags
  logic [6:0]       int_r, int_nxt;          // sticky status
  logic [6:0]       mask_r, mask_nxt;        // interrupt mask
  logic [NUM_CH-1:0] wv_r, wv_nxt;           // waveform levels
  logic [31:0]      rdata_r, rdata_nxt;
  logic             ack_r, ack_nxt;          // one-cycle answer
  logic [NUM_CH-1:0] evo_r, evo_nxt;
  logic [NUM_CH-1:0] evi_r, evi_nxt;
  logic [1:0]       tce_r, tce_nxt;

  // decoded strobes and conditions
  logic              wr_go;                  // accepted write
  logic              at_top, at_zero;
  logic              upd_hw, upd_cmd, do_upd;
  logic [NUM_CH-1:0] match;
  wave_gen_t         wmode;

  // writes commit at the edge that ends the wait, reads load one edge earlier;
  // a frozen clock keeps the wait up so nothing is lost while disabled
  assign wr_go         = i_write && ack_r;
  assign o_waitrequest = (i_read || i_write) && !(ack_r && i_clk_en);
  assign at_top        = (i_count == per_r);
  assign at_zero       = (i_count == '0);
  assign wmode         = wave_gen_t'(wave_r[WGEN_LSB +: 2]);
  // cycle end marks the update point
  assign upd_hw  = i_count_down ? at_zero : at_top;
  assign upd_cmd = wr_go && (i_address == OFS_CTRL_SET) && i_byteenable[0]
                   && (i_writedata[CMD_LSB +: 3] == CMD_UPDATE);
  // command bypasses lock, hardware update waits for unlock
  assign do_upd  = upd_cmd || (upd_hw && !ctrl_r[LOCK_UPDATE_BIT]);

  // compare match per channel
  generate
    for (genvar g = 0; g < NUM_CH; g++)
    begin : g_match
      assign match[g] = (i_count == cc_r[g]);
    end
  endgenerate

  // next-state for registers, buffers and flags
  always_comb
  begin
    ctrl_nxt   = ctrl_r;
    evctrl_nxt = evctrl_r;
    wave_nxt   = wave_r;
    wave_buf_nxt = wave_buf_r;
    per_nxt    = per_r;
    per_buf_nxt = per_buf_r;
    pattern_reg_nxt   = pattern_reg_r;
    pattern_reg_buf_nxt = pattern_reg_buf_r;
    cc_nxt     = cc_r;
    cc_buf_nxt = cc_buf_r;
    bufv_nxt   = bufv_r;
    mask_nxt   = mask_r;
    int_nxt    = int_r;
    // copy valid buffers into active registers
    if (do_upd)
    begin
      if (bufv_r[PATTBV_BIT]) pattern_reg_nxt = pattern_reg_buf_r;
      if (bufv_r[WAVEBV_BIT]) wave_nxt = wave_buf_r;
      if (bufv_r[PERBV_BIT])  per_nxt  = per_buf_r;
      for (int c = 0; c < NUM_CH; c++)
      begin
        if (bufv_r[CCBV_LSB + c]) cc_nxt[c] = cc_buf_r[c];
      end
      int_nxt  = int_r | bufv_r;     // copy event per buffer
      bufv_nxt = '0;
    end
    // software writes; staging sets the valid flag after a copy clears
    if (wr_go)
    begin
      case (i_address)
        OFS_CTRL_B:   ctrl_nxt = be_merge(ctrl_r, i_writedata, i_byteenable);
        OFS_CTRL_CLR: if (i_byteenable[0])
                      begin
                        ctrl_nxt[1:0] = ctrl_r[1:0] & ~i_writedata[1:0];
                      end
        OFS_CTRL_SET: if (i_byteenable[0])
                      begin
                        ctrl_nxt[1:0] = ctrl_r[1:0] | i_writedata[1:0];
                      end
        OFS_EVCTRL:   evctrl_nxt = be_merge(evctrl_r, i_writedata,
                                            i_byteenable);
        OFS_WAVE_BUF:
        begin
          wave_buf_nxt = be_merge(wave_buf_r, i_writedata, i_byteenable);
          bufv_nxt[WAVEBV_BIT] = 1'b1;
        end
        OFS_PER_BUF:
        begin
          per_buf_nxt = CNT_W'(be_merge({16'h0000, per_buf_r}, i_writedata,
                                        i_byteenable));
          bufv_nxt[PERBV_BIT] = 1'b1;
        end
        OFS_PATTERN_REG_BUF:
        begin
          pattern_reg_buf_nxt = 8'(be_merge({24'h000000, pattern_reg_buf_r}, i_writedata,
                                     i_byteenable));
          bufv_nxt[PATTBV_BIT] = 1'b1;
        end
        OFS_INT_FLAG: int_nxt  = int_nxt & ~i_writedata[6:0];
        OFS_INT_MASK: mask_nxt = i_writedata[6:0];
        default:
        begin
          // compare buffers occupy four consecutive words
          if (i_address >= OFS_CC0_BUF && i_address < OFS_INT_FLAG)
          begin
            cc_buf_nxt[i_address[1:0]] = CNT_W'(be_merge(
              {16'h0000, cc_buf_r[i_address[1:0]]}, i_writedata,
              i_byteenable));
            bufv_nxt[CCBV_LSB + 32'(i_address[1:0])] = 1'b1;
          end
        end
      endcase
      // a copy in this cycle still sets its flag over the clear
      if (do_upd && i_address == OFS_INT_FLAG)
      begin
        int_nxt = (int_r & ~i_writedata[6:0]) | bufv_r;
      end
    end
  end

  // waveform level next-state
  always_comb
  begin
    wv_nxt = wv_r;
    for (int c = 0; c < NUM_CH; c++)
    begin
      case (wmode)
        WG_NPWM:
        begin
          if (!i_count_down)
          begin
            if (!wave_r[POL_LSB + c])
            begin
              if (match[c])    wv_nxt[c] = 1'b0;
              else if (at_top) wv_nxt[c] = 1'b1;
            end
            else
            begin
              if (at_top)        wv_nxt[c] = 1'b0;
              else if (match[c]) wv_nxt[c] = 1'b1;
            end
          end
          else
          begin
            if (!wave_r[POL_LSB + c])
            begin
              if (at_zero)       wv_nxt[c] = 1'b0;
              else if (match[c]) wv_nxt[c] = 1'b1;
            end
            else
            begin
              if (match[c])     wv_nxt[c] = 1'b0;
              else if (at_zero) wv_nxt[c] = 1'b1;
            end
          end
        end
        WG_DSPWM:
        begin
          if (match[c])
          begin
            // up-match sets for pol0, down-match sets for pol1
            wv_nxt[c] = i_count_down ~^ wave_r[POL_LSB + c];
          end
        end
        default:
        begin
          // normal and match frequency start from the polarity level
          if (wave_r[WGEN_LSB +: 2] != wave_buf_r[WGEN_LSB +: 2] &&
              do_upd && bufv_r[WAVEBV_BIT])
          begin
            wv_nxt[c] = wave_buf_r[POL_LSB + c];
          end
          else if (match[c] && wmode == WG_MFRQ)
          begin
            wv_nxt[c] = ~wv_r[c];
          end
        end
      endcase
    end
    // outside pwm modes with no toggle the level follows polarity
    if (wmode == WG_NORMAL)
    begin
      wv_nxt = wave_r[POL_LSB +: NUM_CH];
    end
  end

  // event gating and register read
  always_comb
  begin
    evo_nxt = match & evctrl_r[MCEO_LSB +: NUM_CH];
    evi_nxt = i_ch_event & evctrl_r[MCEI_LSB +: NUM_CH];
    tce_nxt = (i_tc_event ^ evctrl_r[TCINV_LSB +: 2])
              & evctrl_r[TCEI_LSB +: 2];
    ack_nxt = (i_read || i_write) && !ack_r;
    rdata_nxt = RST_ZERO;
    if (i_read && !ack_r)
    begin
      case (i_address)
        OFS_CTRL_B, OFS_CTRL_CLR, OFS_CTRL_SET:
                      rdata_nxt = {30'h0, ctrl_r[1:0]};
        OFS_STATUS:   rdata_nxt = {25'h0, bufv_r};
        OFS_EVCTRL:   rdata_nxt = evctrl_r & 32'h0F0F_F7FF;
        OFS_WAVE_BUF: rdata_nxt = wave_buf_r;
        OFS_PER_BUF:  rdata_nxt = {16'h0000, per_buf_r};
        OFS_PATTERN_REG_BUF: rdata_nxt = {24'h000000, pattern_reg_buf_r};
        OFS_INT_FLAG: rdata_nxt = {25'h0, int_r};
        OFS_INT_MASK: rdata_nxt = {25'h0, mask_r};
        OFS_ACTIVE:   rdata_nxt = {per_r, wave_r[15:0]};
        default:
        begin
          if (i_address >= OFS_CC0_BUF && i_address < OFS_INT_FLAG)
          begin
            rdata_nxt = {16'h0000, cc_buf_r[i_address[1:0]]};
          end
        end
      endcase
    end
  end

  // state registers
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      ctrl_r      <= RST_ZERO;
      evctrl_r    <= RST_ZERO;
      wave_r      <= RST_ZERO;
      wave_buf_r  <= RST_ZERO;
      per_r       <= RST_PER;
      per_buf_r   <= RST_PER;
      pattern_reg_r      <= 8'h00;
      pattern_reg_buf_r  <= 8'h00;
      for (int c = 0; c < NUM_CH; c++)
      begin
        cc_r[c]     <= '0;
        cc_buf_r[c] <= '0;
      end
      bufv_r      <= '0;
      int_r       <= '0;
      mask_r      <= '0;
      wv_r        <= '0;
      rdata_r     <= RST_ZERO;
      ack_r       <= 1'b0;
      evo_r       <= '0;
      evi_r       <= '0;
      tce_r       <= '0;
    end
    else if (i_clk_en)
    begin
      ctrl_r      <= ctrl_nxt;
      evctrl_r    <= evctrl_nxt;
      wave_r      <= wave_nxt;
      wave_buf_r  <= wave_buf_nxt;
      per_r       <= per_nxt;
      per_buf_r   <= per_buf_nxt;
      pattern_reg_r      <= pattern_reg_nxt;
      pattern_reg_buf_r  <= pattern_reg_buf_nxt;
      cc_r        <= cc_nxt;
      cc_buf_r    <= cc_buf_nxt;
      bufv_r      <= bufv_nxt;
      int_r       <= int_nxt;
      mask_r      <= mask_nxt;
      wv_r        <= wv_nxt;
      rdata_r     <= rdata_nxt;
      ack_r       <= ack_nxt;
      evo_r       <= evo_nxt;
      evi_r       <= evi_nxt;
      tce_r       <= tce_nxt;
    end
  end

  // outputs
  assign o_readdata    = rdata_r;
  assign o_wave        = wv_r;
  assign o_pattern     = pattern_reg_r[NUM_CH-1:0];
  assign o_period      = per_r;
  assign o_ch_event    = evo_r;
  assign o_ch_event_in = evi_r;
  assign o_tc_event    = tce_r;
  assign o_irq         = |(int_r & mask_r);

  // assertions
  a_lock_holds_flags: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b)
    (i_clk_en && ctrl_r[LOCK_UPDATE_BIT] && !upd_cmd && !wr_go)
      |=> (bufv_r == $past(bufv_r)))
    else $error("valid flags changed while locked");
  a_update_clears_flags: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b)
    (i_clk_en && do_upd && !wr_go) |=> (bufv_r == '0))
    else $error("valid flags not cleared after update");
  a_cmd_copies_period: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b)
    (i_clk_en && upd_cmd && bufv_r[PERBV_BIT]) |=> (per_r == $past(per_buf_r)))
    else $error("update command did not copy period");
  a_hw_copies_cc0: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b)
    (i_clk_en && upd_hw && !ctrl_r[LOCK_UPDATE_BIT] && bufv_r[CCBV_LSB])
      |=> (cc_r[0] == $past(cc_buf_r[0])))
    else $error("compare 0 not copied at update");
  a_write_sets_valid: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b)
    (i_clk_en && wr_go && i_address == OFS_PER_BUF) |=> bufv_r[PERBV_BIT])
    else $error("period buffer valid not set");
  a_up_pol0_clear: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b)
    (i_clk_en && wmode == WG_NPWM && !i_count_down && !wave_r[POL_LSB]
     && match[0]) |=> !wv_r[0])
    else $error("output not cleared on match");
  a_up_pol1_set: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b)
    (i_clk_en && wmode == WG_NPWM && !i_count_down && wave_r[POL_LSB]
     && match[0] && !at_top) |=> wv_r[0])
    else $error("output not set on match");
  a_down_pol0_clear: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b)
    (i_clk_en && wmode == WG_NPWM && i_count_down && !wave_r[POL_LSB]
     && at_zero) |=> !wv_r[0])
    else $error("output not cleared at zero");
  a_dual_pol0_set: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b)
    (i_clk_en && wmode == WG_DSPWM && !i_count_down && !wave_r[POL_LSB]
     && match[0]) |=> wv_r[0])
    else $error("dual slope up match did not set");
  a_event_gate: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b)
    (i_clk_en && !evctrl_r[MCEO_LSB]) |=> !o_ch_event[0])
    else $error("event emitted while disabled");
  c_cmd_update: cover property (@(posedge i_core_clk) disable iff (!i_rst_b)
    upd_cmd && ctrl_r[LOCK_UPDATE_BIT]);
  c_hw_update: cover property (@(posedge i_core_clk) disable iff (!i_rst_b)
    upd_hw && |bufv_r && !ctrl_r[LOCK_UPDATE_BIT]);
  c_dual_slope: cover property (@(posedge i_core_clk) disable iff (!i_rst_b)
    wmode == WG_DSPWM && match[0]);
endmodule : pwm_dbuf

// ---- tb/pwm_count_model.sv ----
// counter core stand-in feeding count value and direction to the stage
// assumes the stage's core clock and its active-low async reset
module pwm_count_model
(
  // clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_b,
  // top value and slope kind: 0 up, 1 down, 2 dual
  input  wire logic [15:0] i_top,
  input  wire logic [1:0]  i_kind,
  // counter state
  output logic      [15:0] o_count,
  output logic             o_down
);
  timeunit 1ns;
  timeprecision 1ps;

  // one step a clock, turning at top and at zero
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_count <= 16'h0000;
      o_down  <= 1'b0;
    end
    else if (i_kind == 2'h0)
    begin
      // up: a shrunk top must not strand the count above it
      o_down  <= 1'b0;
      o_count <= (o_count >= i_top) ? 16'h0000 : o_count + 16'h0001;
    end
    else if (i_kind == 2'h1)
    begin
      // down: reload top after zero
      o_down  <= 1'b1;
      o_count <= (o_count == 16'h0000 || o_count > i_top) ? i_top
                                                          : o_count - 16'h0001;
    end
    else if (!o_down && o_count >= i_top)
    begin
      // dual: turn down at top
      o_down  <= 1'b1;
      o_count <= i_top - 16'h0001;
    end
    else if (o_down && o_count == 16'h0000)
    begin
      // dual: turn up at zero
      o_down  <= 1'b0;
      o_count <= 16'h0001;
    end
    else
    begin
      o_count <= o_down ? o_count - 16'h0001 : o_count + 16'h0001;
    end
  end
endmodule : pwm_count_model

// ---- tb/pwm_polarity_double_buffer_tb_top.sv ----
// self-checking bench for the polarity-aware pwm stage with buffering
// assumes the package, the stage and the counter model compiled first
module pwm_polarity_double_buffer_tb_top
  import pwm_dbuf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic              clk;         // core clock
  logic              rst_b;       // reset, low active
  logic [ADDR_W-1:0] addr;        // bus word address
  logic              rd;          // bus read
  logic              wr;          // bus write
  logic [31:0]       wdata;       // bus write data
  logic [31:0]       rdata;       // bus read data
  logic              waitreq;     // bus stall
  logic [CNT_W-1:0]  count;       // counter value
  logic              count_down;  // counter direction
  logic [NUM_CH-1:0] ch_ev;       // channel events in
  logic [1:0]        tc_ev;       // counter events in
  logic [NUM_CH-1:0] ch_ev_out;   // match events out
  logic [NUM_CH-1:0] ch_ev_in;    // gated channel events
  logic [1:0]        tc_ev_out;   // gated counter events
  logic [NUM_CH-1:0] wave;        // waveform levels
  logic [CNT_W-1:0]  period;      // active period
  logic [NUM_CH-1:0] pattern;     // active pattern bits
  logic              irq;         // interrupt level
  logic [1:0]        kind;        // counter slope kind
  int                miscompares; // mismatches seen
  int                comparisons; // checks made

  // stage under test, always clock-enabled
  pwm_dbuf uut (.i_core_clk(clk), .i_rst_b(rst_b), .i_clk_en(1'b1),
    .i_address(addr), .i_read(rd), .i_write(wr), .i_writedata(wdata),
    .i_byteenable(4'hF), .o_readdata(rdata), .o_waitrequest(waitreq),
    .i_count(count), .i_count_down(count_down), .i_ch_event(ch_ev),
    .i_tc_event(tc_ev), .o_ch_event(ch_ev_out), .o_ch_event_in(ch_ev_in),
    .o_tc_event(tc_ev_out), .o_wave(wave), .o_pattern(pattern),
    .o_period(period), .o_irq(irq));

  // counter core runs off the active period
  pwm_count_model u_cnt (.i_core_clk(clk), .i_rst_b(rst_b), .i_top(period),
    .i_kind(kind), .o_count(count), .o_down(count_down));

  // compare and count
  task automatic chk(input string s, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask : chk

  // one access, request held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    addr  <= a;
    rd    <= !w;
    wr    <= w;
    wdata <= d;
    @(posedge clk);
    // waitrequest and read data seen here are those standing at this edge
    while (waitreq !== 1'b0 && n < 50)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 50)
      miscompares++;
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wreg

  task automatic rchk(input string s, input logic [3:0] a,
                      input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    chk(s, e, q);
  endtask : rchk

  // bounded waits, all ending on a falling edge
  task automatic cycles(input int n);
    repeat (n) @(negedge clk);
  endtask : cycles

  task automatic wait_cnt(input logic [15:0] v);
    int n;
    n = 0;
    @(negedge clk);
    while (count !== v && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 200)
      miscompares++;
  endtask : wait_cnt

  task automatic wait_per(input logic [15:0] v);
    int n;
    n = 0;
    @(negedge clk);
    while (period !== v && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 200)
      miscompares++;
  endtask : wait_per

  // events held one edge, then looked at
  task automatic ev(input logic [3:0] c, input logic [1:0] t);
    @(posedge clk);
    ch_ev <= c;
    tc_ev <= t;
    @(posedge clk);
    @(negedge clk);
  endtask : ev

  // reset values, read-only status and an unmapped word
  task automatic t_reset;
    chk("period", 32'(RST_PER), 32'(period));
    chk("wave", 32'h0, 32'(wave));
    rchk("status", OFS_STATUS, 32'h0);
    rchk("unmapped", 4'hF, 32'h0);
    wreg(OFS_STATUS, 32'hFF);
    rchk("status ro", OFS_STATUS, 32'h0);
    rchk("evctrl", OFS_EVCTRL, 32'h0);
  endtask : t_reset

  // command copies despite lock; irq masked, raised, cleared
  task automatic t_update;
    wreg(OFS_CTRL_SET, 32'h2);
    wreg(OFS_PER_BUF, 32'h14);
    rchk("per valid", OFS_STATUS, 32'h4);
    wreg(OFS_CTRL_SET, 32'h60);
    wait_per(16'h14);
    chk("period cmd", 32'h14, 32'(period));
    rchk("valid clr", OFS_STATUS, 32'h0);
    chk("irq masked", 32'h0, 32'(irq));
    wreg(OFS_INT_MASK, 32'hFF);
    @(negedge clk);
    chk("irq up", 32'h1, 32'(irq));
    wreg(OFS_INT_FLAG, 32'hFF);
    @(negedge clk);
    chk("irq clr", 32'h0, 32'(irq));
  endtask : t_update

  // lock holds across tops; unlock copies at top
  task automatic t_lock;
    wreg(OFS_PER_BUF, 32'h1E);
    cycles(80);
    chk("per held", 32'h14, 32'(period));
    rchk("valid held", OFS_STATUS, 32'h4);
    wreg(OFS_CTRL_CLR, 32'h2);
    wait_per(16'h1E);
    chk("per copied", 32'h1E, 32'(period));
    chk("copy at top", 32'h0, 32'(count));
    rchk("valid auto", OFS_STATUS, 32'h0);
    rchk("int copy", OFS_INT_FLAG, 32'h4);
  endtask : t_lock

  // pwm set/clear: level at count 14 and at count 4, compare at 8
  task automatic t_pwm(input logic [1:0] k, input logic p, input logic e);
    kind <= k;
    wreg(OFS_WAVE_BUF, {12'h000, {4{p}}, 14'h0000,
                        (k == 2'h2) ? WG_DSPWM : WG_NPWM});
    for (int c = 0; c < 4; c++)
      wreg(OFS_CC0_BUF + 4'(c), 32'h8);
    wreg(OFS_CTRL_SET, 32'h60);
    cycles(70);
    wait_cnt(16'hE);
    chk("wave mid", {28'h0, {4{e ^ p}}}, 32'(wave));
    wait_cnt(16'h4);
    chk("wave low", {28'h0, {4{~(e ^ p)}}}, 32'(wave));
  endtask : t_pwm

  // normal mode shows polarity as level
  task automatic t_normal;
    wreg(OFS_WAVE_BUF, 32'h000A_0000);
    wreg(OFS_PATTERN_REG_BUF, 32'h5);
    wreg(OFS_CTRL_SET, 32'h60);
    cycles(3);
    chk("normal pol", 32'hA, 32'(wave));
    chk("pattern", 32'h5, 32'(pattern));
    rchk("active", OFS_ACTIVE, 32'h001E_0000);
  endtask : t_normal

  // event gating and inversion
  task automatic t_events;
    logic [3:0] seen;
    seen = 4'h0;
    wreg(OFS_EVCTRL, 32'h0105_D000);
    rchk("evctrl rw", OFS_EVCTRL, 32'h0105_D000);
    ev(4'hF, 2'h0);
    chk("ch in", 32'h5, 32'(ch_ev_in));
    chk("tc inv", 32'h1, 32'(tc_ev_out));
    ev(4'h0, 2'h3);
    chk("tc in", 32'h2, 32'(tc_ev_out));
    repeat (70)
    begin
      @(negedge clk);
      seen |= ch_ev_out;
    end
    chk("ch out", 32'h1, 32'(seen));
    wreg(OFS_EVCTRL, 32'h0);
    ev(4'hF, 2'h3);
    chk("tc off", 32'h0, 32'(tc_ev_out));
    chk("ch off", 32'h0, 32'(ch_ev_in));
  endtask : t_events

  // verdict and end of run
  task automatic close_out;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out

  // free-running clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // main sequence
  initial
  begin
    miscompares = 0;
    comparisons = 0;
    rst_b = 1'b0;
    addr = 4'h0;
    rd = 1'b0;
    wr = 1'b0;
    wdata = 32'h0;
    ch_ev = 4'h0;
    tc_ev = 2'h0;
    kind = 2'h0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    t_reset;
    t_update;
    t_lock;
    t_pwm(2'h0, 1'b0, 1'b0);
    t_pwm(2'h0, 1'b1, 1'b0);
    t_pwm(2'h1, 1'b0, 1'b0);
    t_pwm(2'h1, 1'b1, 1'b0);
    t_pwm(2'h2, 1'b0, 1'b1);
    t_pwm(2'h2, 1'b1, 1'b1);
    t_normal;
    t_events;
    close_out;
  end

  // hang guard, about twenty times the expected run
  initial
  begin
    #160000;
    miscompares++;
    close_out;
  end
endmodule : pwm_polarity_double_buffer_tb_top
